// *** lssr_consts.svh ***
// Purpose: register offsets, field positions, reset values and timing
//          counts for the line sense status registers
// Assumes: 8-bit register offsets, 8-bit register data
// Notes:   included by its bare name
`ifndef LSSR_CONSTS_SVH
`define LSSR_CONSTS_SVH

`define LSSR_ADDR_W 8
`define LSSR_DATA_W 8

`define LSSR_OFS_FAULT_FLAG 8'h03
`define LSSR_OFS_INT_ENABLE 8'h05
`define LSSR_OFS_DET_ENABLE 8'h12
`define LSSR_OFS_UV_ENABLE 8'h15
`define LSSR_OFS_RING 8'h1a
`define LSSR_OFS_LINE_V 8'h1b
`define LSSR_OFS_LOOP_I 8'h1c
`define LSSR_OFS_UV_STATE 8'h1e

`define LSSR_BIT_FAULT_FLAG 2
`define LSSR_BIT_INT_ENABLE 2
`define LSSR_BIT_DET_ENABLE 1
`define LSSR_BIT_UV_ENABLE 2
`define LSSR_BIT_UV_STATE 6

`define LSSR_RST_INT_ENABLE 1'b0
`define LSSR_RST_DET_ENABLE 1'b0
`define LSSR_RST_UV_ENABLE 1'b0
`define LSSR_RST_FAULT_FLAG 1'b0

// wide bandwidth is held this long after an under-voltage clears
`define LSSR_UV_HOLD_CYCLES 16

`endif

// *** lssr_pkg.sv ***
// Purpose: types shared by the line sense status register files
// Assumes: nothing
// Notes:   constants live in lssr_consts.svh
package lssr_pkg;

    typedef enum logic [2:0] {
        LSSR_BW_NORMAL = 3'b001,
        LSSR_BW_WIDE = 3'b010,
        LSSR_BW_HOLD = 3'b100
    } lssr_bw_state_type;

    typedef enum logic [1:0] {
        LSSR_ADC_RING = 2'h0,
        LSSR_ADC_LINE_V = 2'h1,
        LSSR_ADC_LOOP_I = 2'h2
    } lssr_adc_chan_type;

endpackage : lssr_pkg

// *** lssr_sync.sv ***
// Purpose: two-flop synchroniser for asynchronous detector levels
// Assumes: inputs are slow levels, not pulses
// Notes:   first stage is read only by the second stage
module lssr_sync #(
    parameter int WIDTH = 3
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_q;
            logic meta_d;
            logic stable_q;
            logic stable_d;
            always_comb begin
                meta_d = async_in[i];
                stable_d = meta_q;
            end
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q <= 1'b0;
                    stable_q <= 1'b0;
                end else begin
                    meta_q <= meta_d;
                    stable_q <= stable_d;
                end
            end
            assign sync_out[i] = stable_q;
        end
    endgenerate

endmodule : lssr_sync

// *** lssr_adc_capture.sv ***
// Purpose: capture auxiliary A/D results into the three readout fields
// Assumes: adc_valid, adc_chan and adc_data come from logic on mclk
// Notes:   fields keep their last sample until a new one arrives
`include "lssr_consts.svh"

module lssr_adc_capture (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic adc_valid,
    input wire logic [1:0] adc_chan,
    input wire logic [7:0] adc_data,
    output logic [7:0] ring_q,
    output logic [6:0] line_v_q,
    output logic [6:0] loop_i_q
);

    logic [7:0] ring_d;
    logic [6:0] line_v_d;
    logic [6:0] loop_i_d;

    always_comb begin
        ring_d = ring_q;
        line_v_d = line_v_q;
        loop_i_d = loop_i_q;
        if (adc_valid) begin
            unique case (adc_chan)
                lssr_pkg::LSSR_ADC_RING: begin
                    ring_d = adc_data;
                end
                lssr_pkg::LSSR_ADC_LINE_V: begin
                    line_v_d = adc_data[7:1];
                end
                lssr_pkg::LSSR_ADC_LOOP_I: begin
                    loop_i_d = adc_data[6:0];
                end
                default: begin
                    ring_d = ring_q;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ring_q <= 8'h00;
            line_v_q <= 7'h00;
            loop_i_q <= 7'h00;
        end else begin
            ring_q <= ring_d;
            line_v_q <= line_v_d;
            loop_i_q <= loop_i_d;
        end
    end

endmodule : lssr_adc_capture

// *** lssr_top.sv ***
// Purpose: line sensing status and fault register logic
// Assumes: single-cycle register strobes on mclk; detector pins async
// Notes:   read data answers one cycle after the read strobe
`include "lssr_consts.svh"

module lssr_top #(
    parameter int UV_HOLD_CYCLES = `LSSR_UV_HOLD_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic adc_valid,
    input wire logic [1:0] adc_chan,
    input wire logic [7:0] adc_data,
    input wire logic undervolt_condition,
    input wire logic overvolt_condition,
    input wire logic overcurrent_condition,
    input wire logic nominal_bandwidth_cfg,
    output logic nominal_bandwidth_select,
    output logic fault_irq
);

    localparam int HOLD_W = $clog2(UV_HOLD_CYCLES + 1);
    localparam logic [HOLD_W-1:0] HOLD_LOAD =
        HOLD_W'(UV_HOLD_CYCLES);

    // synchronised detector levels
    logic [2:0] cond_raw;
    logic [2:0] cond_sync;
    logic uv_sync;
    logic ov_sync;
    logic oc_sync;

    // A/D readout fields
    logic [7:0] ring_voltage_sample;
    logic [6:0] line_voltage_level;
    logic [6:0] loop_current_level;

    // software controls
    logic fault_interrupt_enable_q;
    logic fault_interrupt_enable_d;
    logic line_detectors_enable_q;
    logic line_detectors_enable_d;
    logic undervolt_detector_enable_q;
    logic undervolt_detector_enable_d;

    // fault flag and interrupt
    logic fault_event_flag_q;
    logic fault_event_flag_d;
    logic fault_irq_q;
    logic fault_irq_d;
    logic uv_active;
    logic ov_active;
    logic oc_active;
    logic fault_any;
    logic rd_fault;

    // status and read port
    logic undervolt_state_q;
    logic undervolt_state_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    // bandwidth override
    lssr_pkg::lssr_bw_state_type bw_state_q;
    lssr_pkg::lssr_bw_state_type bw_state_d;
    logic [HOLD_W-1:0] hold_cnt_q;
    logic [HOLD_W-1:0] hold_cnt_d;
    logic bw_select_q;
    logic bw_select_d;

    assign cond_raw = {overcurrent_condition, overvolt_condition,
                       undervolt_condition};

    lssr_sync #(
        .WIDTH(3)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in(cond_raw),
        .sync_out(cond_sync)
    );

    assign uv_sync = cond_sync[0];
    assign ov_sync = cond_sync[1];
    assign oc_sync = cond_sync[2];

    lssr_adc_capture u_adc (
        .mclk(mclk),
        .rst_n(rst_n),
        .adc_valid(adc_valid),
        .adc_chan(adc_chan),
        .adc_data(adc_data),
        .ring_q(ring_voltage_sample),
        .line_v_q(line_voltage_level),
        .loop_i_q(loop_current_level)
    );

    // ------------------------------------------------------------
    // detector gating
    // ------------------------------------------------------------
    always_comb begin
        uv_active = line_detectors_enable_q &
                    undervolt_detector_enable_q & uv_sync;
        ov_active = line_detectors_enable_q & ov_sync;
        oc_active = line_detectors_enable_q & oc_sync;
        fault_any = uv_active | ov_active | oc_active;
    end

    // ------------------------------------------------------------
    // control register writes
    // ------------------------------------------------------------
    always_comb begin
        fault_interrupt_enable_d = fault_interrupt_enable_q;
        line_detectors_enable_d = line_detectors_enable_q;
        undervolt_detector_enable_d = undervolt_detector_enable_q;
        if (reg_wr) begin
            unique case (reg_addr)
                `LSSR_OFS_INT_ENABLE: begin
                    fault_interrupt_enable_d =
                        reg_wdata[`LSSR_BIT_INT_ENABLE];
                end
                `LSSR_OFS_DET_ENABLE: begin
                    line_detectors_enable_d =
                        reg_wdata[`LSSR_BIT_DET_ENABLE];
                end
                `LSSR_OFS_UV_ENABLE: begin
                    undervolt_detector_enable_d =
                        reg_wdata[`LSSR_BIT_UV_ENABLE];
                end
                default: begin
                    // unmapped or read-only offsets ignore writes
                    fault_interrupt_enable_d = fault_interrupt_enable_q;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fault_interrupt_enable_q <= `LSSR_RST_INT_ENABLE;
            line_detectors_enable_q <= `LSSR_RST_DET_ENABLE;
            undervolt_detector_enable_q <= `LSSR_RST_UV_ENABLE;
        end else begin
            fault_interrupt_enable_q <= fault_interrupt_enable_d;
            line_detectors_enable_q <= line_detectors_enable_d;
            undervolt_detector_enable_q <= undervolt_detector_enable_d;
        end
    end

    // ------------------------------------------------------------
    // fault flag, clear on read, interrupt
    // ------------------------------------------------------------
    always_comb begin
        rd_fault = reg_rd && (reg_addr == `LSSR_OFS_FAULT_FLAG);
        fault_event_flag_d = fault_event_flag_q;
        if (rd_fault) begin
            fault_event_flag_d = 1'b0;
        end
        // a fault in the clearing cycle survives the read
        if (fault_any) begin
            fault_event_flag_d = 1'b1;
        end
        fault_irq_d = fault_event_flag_d &
                      fault_interrupt_enable_d;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fault_event_flag_q <= `LSSR_RST_FAULT_FLAG;
            fault_irq_q <= 1'b0;
        end else begin
            fault_event_flag_q <= fault_event_flag_d;
            fault_irq_q <= fault_irq_d;
        end
    end

    // ------------------------------------------------------------
    // under-voltage bandwidth override
    // ------------------------------------------------------------
    // wide bandwidth while the condition lasts and a short hold after,
    // so the loop does not snap back while the supply is still settling
    always_comb begin
        bw_state_d = bw_state_q;
        hold_cnt_d = hold_cnt_q;
        unique case (bw_state_q)
            lssr_pkg::LSSR_BW_NORMAL: begin
                if (uv_active) begin
                    bw_state_d = lssr_pkg::LSSR_BW_WIDE;
                end
            end
            lssr_pkg::LSSR_BW_WIDE: begin
                if (!uv_active) begin
                    bw_state_d = lssr_pkg::LSSR_BW_HOLD;
                    hold_cnt_d = HOLD_LOAD;
                end
            end
            lssr_pkg::LSSR_BW_HOLD: begin
                if (uv_active) begin
                    bw_state_d = lssr_pkg::LSSR_BW_WIDE;
                end else if (hold_cnt_q <= HOLD_W'(1)) begin
                    bw_state_d = lssr_pkg::LSSR_BW_NORMAL;
                    hold_cnt_d = '0;
                end else begin
                    hold_cnt_d = hold_cnt_q - HOLD_W'(1);
                end
            end
            default: begin
                bw_state_d = lssr_pkg::LSSR_BW_NORMAL;
                hold_cnt_d = '0;
            end
        endcase
        // 1 selects wide bandwidth
        if (bw_state_d == lssr_pkg::LSSR_BW_NORMAL) begin
            bw_select_d = nominal_bandwidth_cfg;
        end else begin
            bw_select_d = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bw_state_q <= lssr_pkg::LSSR_BW_NORMAL;
            hold_cnt_q <= '0;
            bw_select_q <= 1'b0;
        end else begin
            bw_state_q <= bw_state_d;
            hold_cnt_q <= hold_cnt_d;
            bw_select_q <= bw_select_d;
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    always_comb begin
        undervolt_state_d = uv_active;
        rvalid_d = reg_rd;
        rdata_d = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `LSSR_OFS_FAULT_FLAG: begin
                    rdata_d[`LSSR_BIT_FAULT_FLAG] =
                        fault_event_flag_q;
                end
                `LSSR_OFS_INT_ENABLE: begin
                    rdata_d[`LSSR_BIT_INT_ENABLE] =
                        fault_interrupt_enable_q;
                end
                `LSSR_OFS_RING: begin
                    rdata_d = ring_voltage_sample;
                end
                `LSSR_OFS_LINE_V: begin
                    // bit 0 reads zero; scaled by software
                    rdata_d = {line_voltage_level, 1'b0};
                end
                `LSSR_OFS_LOOP_I: begin
                    rdata_d = {loop_current_level, 1'b0};
                end
                `LSSR_OFS_UV_STATE: begin
                    rdata_d[`LSSR_BIT_UV_STATE] =
                        undervolt_state_q;
                end
                default: begin
                    // write-only and unmapped offsets read zero
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            undervolt_state_q <= 1'b0;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            undervolt_state_q <= undervolt_state_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign fault_irq = fault_irq_q;
    assign nominal_bandwidth_select = bw_select_q;

endmodule : lssr_top

// *** lssr_top_chk.sv ***
// Purpose: port-level assertions for lssr_top
// Assumes: enables are shadowed from register writes seen at the ports
// Notes: counters saturate at 64, enough for every window used here
module lssr_top_chk #(
    parameter int UV_HOLD_CYCLES = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic adc_valid,
    input wire logic [1:0] adc_chan,
    input wire logic [7:0] adc_data,
    input wire logic undervolt_condition,
    input wire logic overvolt_condition,
    input wire logic overcurrent_condition,
    input wire logic nominal_bandwidth_cfg,
    input wire logic nominal_bandwidth_select,
    input wire logic fault_irq
);
    logic det_q, uve_q, en_q, ovc;
    logic [7:0] uvq_q, ucnt_q, fcnt_q, qt_q;
    assign ovc = overvolt_condition | overcurrent_condition;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {det_q, uve_q, en_q} <= 3'h0;
            {uvq_q, ucnt_q, fcnt_q, qt_q} <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == 8'h12) det_q <= reg_wdata[1];
            if (reg_wr && reg_addr == 8'h15) uve_q <= reg_wdata[2];
            if (reg_wr && reg_addr == 8'h05) en_q <= reg_wdata[2];
            uvq_q <= undervolt_condition ? 8'h00 : uvq_q + 8'(uvq_q < 8'h40);
            ucnt_q <= (det_q && uve_q && undervolt_condition) ?
                ucnt_q + 8'(ucnt_q < 8'h40) : 8'h00;
            fcnt_q <= (det_q && en_q && ovc) ?
                fcnt_q + 8'(fcnt_q < 8'h40) : 8'h00;
            qt_q <= (ovc || undervolt_condition) ? 8'h00 :
                qt_q + 8'(qt_q < 8'h40);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_read_answers: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("stray read valid");
    a_idle_rdata: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_level_lsb_zero: assert property ($past(reg_rd) &&
        ($past(reg_addr) == 8'h1b || $past(reg_addr) == 8'h1c)
        |-> reg_rdata[0] == 1'b0) else $error("level bit 0 set");
    a_flag_field: assert property ($past(reg_rd) &&
        $past(reg_addr) == 8'h03 |-> (reg_rdata & 8'hfb) == 8'h00)
        else $error("fault read has stray bits");
    a_irq_needs_en: assert property (
        fault_irq |-> en_q || $past(en_q)) else $error("irq without enable");
    a_irq_on_fault: assert property (
        fcnt_q >= 8'h06 |-> fault_irq) else $error("irq missing on fault");
    a_read_clears: assert property (reg_rd && reg_addr == 8'h03 &&
        qt_q >= 8'h05 |-> ##[1:2] !fault_irq) else $error("irq kept");
    a_uv_wide: assert property (ucnt_q >= 8'h04
        |-> nominal_bandwidth_select) else $error("no wide bandwidth");
    a_bw_cfg: assert property (uvq_q > 8'(UV_HOLD_CYCLES + 5)
        |-> nominal_bandwidth_select == $past(nominal_bandwidth_cfg))
        else $error("bandwidth not back to cfg");
    c_flag_read: cover property (reg_rd && reg_addr == 8'h03 && fault_irq);
    c_uv_wide: cover property (ucnt_q >= 8'h04);
    c_level_read: cover property ($past(reg_rd) && $past(reg_addr) == 8'h1b);
endmodule : lssr_top_chk

bind lssr_top lssr_top_chk #(.UV_HOLD_CYCLES(UV_HOLD_CYCLES)) u_chk (
    .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .adc_valid(adc_valid), .adc_chan(adc_chan),
    .adc_data(adc_data), .undervolt_condition(undervolt_condition),
    .overvolt_condition(overvolt_condition),
    .overcurrent_condition(overcurrent_condition),
    .nominal_bandwidth_cfg(nominal_bandwidth_cfg),
    .nominal_bandwidth_select(nominal_bandwidth_select),
    .fault_irq(fault_irq));

// *** lssr_line_model.sv ***
// Purpose: line-side model: aux converter samples and fault levels
// Assumes: driven 1 ns after the rising edge of mclk
// Notes: data lines show the inverse once a sample has been taken
module lssr_line_model (
    input wire logic mclk,
    output logic adc_valid,
    output logic [1:0] adc_chan,
    output logic [7:0] adc_data,
    output logic [2:0] faults
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {adc_valid, adc_chan, adc_data, faults} = 14'h0;
    // full 8-bit conversion; the block picks its own field
    task automatic sample(input logic [1:0] c, input logic [7:0] d);
        @(posedge mclk);
        #1 {adc_valid, adc_chan, adc_data} = {1'b1, c, d};
        @(posedge mclk);
        #1 {adc_valid, adc_chan, adc_data} = {1'b0, ~c, ~d};
    endtask : sample
    // order is under-voltage, over-voltage, over-current
    task automatic set_faults(input logic [2:0] f);
        @(posedge mclk);
        #1 faults = f;
    endtask : set_faults
endmodule : lssr_line_model

// *** test_line_sense_status_regs.sv ***
// Purpose: self-checking bench for lssr_top against a register model
// Assumes: wide-bandwidth hold shortened to 2 cycles
// Notes: faults are held long enough to pass the synchroniser
module test_line_sense_status_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, cfg = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, adc_data;
    logic reg_rvalid, adc_valid, bw_sel, fault_irq;
    logic [1:0] adc_chan;
    logic [2:0] flt;
    logic [7:0] mreg [256];
    logic m_det, m_uven, m_flag;
    int num_errors = 0, checks_done = 0;
    always #5 mclk = ~mclk;
    lssr_top #(.UV_HOLD_CYCLES(2)) u_dut (.mclk(mclk), .rst_n(rst_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .adc_valid(adc_valid),
        .adc_chan(adc_chan), .adc_data(adc_data),
        .undervolt_condition(flt[2]), .overvolt_condition(flt[1]),
        .overcurrent_condition(flt[0]), .nominal_bandwidth_cfg(cfg),
        .nominal_bandwidth_select(bw_sel), .fault_irq(fault_irq));
    lssr_line_model u_line (.mclk(mclk), .adc_valid(adc_valid),
        .adc_chan(adc_chan), .adc_data(adc_data), .faults(flt));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic do_reset();
        #1 rst_n = 0;
        foreach (mreg[i]) mreg[i] = 8'h00;
        {m_det, m_uven, m_flag} = 3'h0;
        repeat (10) @(posedge mclk);
        #1 rst_n = 1;
    endtask : do_reset
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge mclk);
        #1 reg_wr = 0;
        if (a == 8'h05) mreg[5] = d & 8'h04;
        if (a == 8'h12) m_det = d[1];
        if (a == 8'h15) m_uven = d[2];
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic live);
        logic [7:0] want;
        @(posedge mclk);
        #1 {reg_rd, reg_addr} = {1'b1, a};
        @(posedge mclk);
        #1 reg_rd = 0;
        want = (a == 8'h03) ? {5'h0, m_flag, 2'h0} : mreg[a];
        check(reg_rdata, want);
        check({7'h0, reg_rvalid}, 8'h01);
        if (a == 8'h03) m_flag = live;
    endtask : rd
    task automatic apply(input logic [2:0] f);
        logic live, uv;
        uv = f[2] && m_det && m_uven;
        live = m_det && (f[1] || f[0] || uv);
        cfg = 1'($urandom);
        u_line.set_faults(f);
        repeat (6) @(posedge mclk);
        #1 m_flag = m_flag | live;
        mreg[8'h1e] = {1'b0, uv, 6'h0};
        check({7'h0, fault_irq}, 8'(m_flag && mreg[5][2]));
        check({7'h0, bw_sel}, {7'h0, cfg | uv});
        rd(8'h1e, 0);
        rd(8'h03, live);
        u_line.set_faults(3'h0);
        repeat (8) @(posedge mclk);
        #1 mreg[8'h1e] = 8'h00;
        check({7'h0, bw_sel}, {7'h0, cfg});
        rd(8'h1e, 0);
        rd(8'h03, 0);
        rd(8'h03, 0);
        check({7'h0, fault_irq}, 8'h00);
    endtask : apply
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    initial begin
        #100000;
        num_errors++;
        complete_run();
    end
    initial begin
        logic [7:0] d;
        logic [1:0] c;
        void'($urandom(18946));
        do_reset();
        foreach (mreg[i]) if (i inside {3, 5, 18, 21, 26, 27, 28, 30, 64})
            rd(8'(i), 0);
        for (int i = 0; i < 12; i++) begin
            // channels in turn, so every code, the ignored one too, is seen
            c = 2'(i);
            d = 8'($urandom);
            u_line.sample(c, d);
            if (c == 0) mreg[8'h1a] = d;
            if (c == 1) mreg[8'h1b] = d & 8'hfe;
            if (c == 2) mreg[8'h1c] = {d[6:0], 1'b0};
            rd(8'h1a, 0);
            rd(8'h1b, 0);
            rd(8'h1c, 0);
        end
        wr(8'h1a, 8'($urandom));
        wr(8'h03, 8'hff);
        wr(8'h40, 8'hff);
        rd(8'h1a, 0);
        apply(3'b011);
        wr(8'h12, 8'h02);
        wr(8'h05, 8'h04);
        rd(8'h05, 0);
        for (int k = 0; k < 3; k++) apply(3'(1 << k));
        wr(8'h15, 8'h04);
        apply(3'b100);
        apply(3'b111);
        wr(8'h05, 8'h00);
        apply(3'b010);
        wr(8'h05, 8'h04);
        do_reset();
        rd(8'h05, 0);
        complete_run();
    end
endmodule : test_line_sense_status_regs
